/* design/pdmc_pkg.sv */
package pdmc_pkg;
   localparam int unsigned PDMC_CLK_HZ = 100_000_000;
   localparam int unsigned PDMC_ADDR_W = 4;
   // byte offsets of the register words
   localparam logic [3:0] PDMC_OFS_CSW = 4'h0;
   localparam logic [3:0] PDMC_OFS_IEW = 4'h4;
   localparam logic [3:0] PDMC_OFS_STAT = 4'h8;
   localparam logic [3:0] PDMC_OFS_CFG = 4'hC;
   // control status word fields; the nonmaskable enable bit indexes iew, not this word
   localparam int unsigned PDMC_PDS_LSB = 10;
   localparam int unsigned PDMC_PDS_W = 6;
   localparam int unsigned PDMC_GLB_EN_BIT = 0;
   localparam int unsigned PDMC_NMI_EN_BIT = 1;
   localparam logic [5:0] PDMC_PDS_NONE = 6'h00;
   localparam logic [5:0] PDMC_PDS_LIGHT_EN = 6'h09;
   localparam logic [5:0] PDMC_PDS_LIGHT_ANY = 6'h11;
   localparam logic [5:0] PDMC_PDS_HALT = 6'h1A;
   localparam logic [5:0] PDMC_PDS_PLLSTOP = 6'h1C;
   localparam logic [31:0] PDMC_CSW_RST = 32'h0000_0000;
   localparam logic [31:0] PDMC_CSW_WMASK = 32'h0000_FC03;
   localparam logic [1:0] PDMC_RESP_OK = 2'h0;
   localparam logic [1:0] PDMC_RESP_SLVERR = 2'h2;
   // light sleep takes effect this many cycles after the write
   localparam logic [3:0] PDMC_LIGHT_DLY = 4'h8;
   // pll lock: typical 75 us, worst case 150 % longer
   localparam int unsigned PDMC_LOCK_TYP_US = 75;
   localparam int unsigned PDMC_LOCK_PCT = 150;
   localparam int unsigned PDMC_LOCK_CYC =
      (PDMC_LOCK_TYP_US * (100 + PDMC_LOCK_PCT) / 100) * (PDMC_CLK_HZ / 1_000_000);
   typedef enum logic [2:0] {
      PDMC_RUN = 3'b000,
      PDMC_ARM = 3'b001,
      PDMC_LIGHT = 3'b010,
      PDMC_HALT = 3'b011,
      PDMC_PLLSTOP = 3'b100,
      PDMC_LOCK = 3'b101
   } pdmc_state_t;
endpackage

/* design/pdmc_sync.sv */
`timescale 1ns/1ps
module pdmc_sync
   import pdmc_pkg::*;
#(
   parameter int unsigned W = 1
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } pdmc_sync_st_t;
   pdmc_sync_st_t q, d;
   always_comb begin
      d = q;
      d.s1 = async_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a change counts only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign level_o = q.lvl;
endmodule

/* design/pdmc_axil.sv */
`timescale 1ns/1ps
module pdmc_axil
   import pdmc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [PDMC_ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [PDMC_ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic wr_o,
   output logic [PDMC_ADDR_W-1:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   output logic [PDMC_ADDR_W-1:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_ok_i,
   input wire logic wr_ok_i
);
   typedef struct packed {
      logic aw_h;
      logic w_h;
      logic [PDMC_ADDR_W-1:0] aw;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } pdmc_axil_st_t;
   pdmc_axil_st_t q, d;
   logic do_wr;
   always_comb begin
      d = q;
      if (awvalid_i && awready_o) begin
         d.aw_h = 1'b1;
         d.aw = awaddr_i;
      end
      if (wvalid_i && wready_o) begin
         d.w_h = 1'b1;
         d.wd = wdata_i;
         d.ws = wstrb_i;
      end
      do_wr = q.aw_h && q.w_h && !q.bv;
      if (do_wr) begin
         d.aw_h = 1'b0;
         d.w_h = 1'b0;
         d.bv = 1'b1;
         d.br = wr_ok_i ? PDMC_RESP_OK : PDMC_RESP_SLVERR;
      end
      if (q.bv && bready_i) begin
         d.bv = 1'b0;
      end
      if (arvalid_i && arready_o) begin
         d.rv = 1'b1;
         d.rd = rd_ok_i ? rd_data_i : 32'h0000_0000;
         d.rr = rd_ok_i ? PDMC_RESP_OK : PDMC_RESP_SLVERR;
      end else if (q.rv && rready_i) begin
         d.rv = 1'b0;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign awready_o = !q.aw_h && !q.bv;
   assign wready_o = !q.w_h && !q.bv;
   assign arready_o = !q.rv;
   assign bvalid_o = q.bv;
   assign bresp_o = q.br;
   assign rvalid_o = q.rv;
   assign rdata_o = q.rd;
   assign rresp_o = q.rr;
   assign wr_o = do_wr;
   assign wr_addr_o = q.aw;
   assign wr_data_o = q.wd;
   assign wr_strb_o = q.ws;
   assign rd_addr_o = araddr_i;
endmodule

/* design/pdmc_top.sv */
// Behaviour
// - mode comes from bits 15..10 of control word; zero is run, codes not listed below reserved
// - light sleep takes effect eight to nine cycles after the write
// - code 001001 is light sleep woken by enabled interrupt; cpu clock gated
// - code 010001 is light sleep woken by any interrupt
// - wake by non-enabled interrupt resumes without service routine
// - wake by enabled interrupt runs the service routine first
// - service routine needs global and nonmaskable enables both set; code reads the nonmaskable one from iew bit 1
// - code 011010 stops the pll output clock, halting the chip
// - code 011100 stops the pll input clock
// - only device reset ends the two deep modes
// - deep modes preserve registers; functional outputs freeze
// - after reset from deepest mode wait for pll relock, 75 us +150 %
// - one-to-one mode bypasses pll; four-times mode uses pll
`timescale 1ns/1ps
module pdmc_top
   import pdmc_pkg::*;
#(
   parameter int unsigned LOCK_CYC = PDMC_LOCK_CYC,
   parameter int unsigned IRQ_W = 16
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [PDMC_ADDR_W-1:0] s_axil_awaddr_i,
   input wire logic s_axil_awvalid_i,
   output logic s_axil_awready_o,
   input wire logic [31:0] s_axil_wdata_i,
   input wire logic [3:0] s_axil_wstrb_i,
   input wire logic s_axil_wvalid_i,
   output logic s_axil_wready_o,
   output logic [1:0] s_axil_bresp_o,
   output logic s_axil_bvalid_o,
   input wire logic s_axil_bready_i,
   input wire logic [PDMC_ADDR_W-1:0] s_axil_araddr_i,
   input wire logic s_axil_arvalid_i,
   output logic s_axil_arready_o,
   output logic [31:0] s_axil_rdata_o,
   output logic [1:0] s_axil_rresp_o,
   output logic s_axil_rvalid_o,
   input wire logic s_axil_rready_i,
   input wire logic [IRQ_W-1:0] irq_i,
   input wire logic pll_reset_wake_i,
   input wire logic clock_multiplier_select_i,
   input wire logic pll_locked_i,
   output logic cpu_clock_en_o,
   output logic dma_clock_en_o,
   output logic intr_logic_en_o,
   output logic pll_bypass_o,
   output logic pll_out_en_o,
   output logic pll_in_en_o,
   output logic io_freeze_o,
   output logic wake_isr_o,
   output logic wake_resume_o,
   output logic [2:0] mode_o
);
   typedef struct packed {
      pdmc_state_t st;
      logic [31:0] csw;
      logic [IRQ_W-1:0] iew;
      logic [3:0] dly;
      logic [31:0] lock_cnt;
      logic isr;
      logic resume;
      logic pll_wait;
      logic strap_done;
      logic x1;
      logic [5:0] armed;
   } pdmc_st_t;
   pdmc_st_t q, d;
   logic [IRQ_W-1:0] irq_s;
   logic relock_s;
   logic wr;
   logic [PDMC_ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic rd_ok, wr_ok;
   logic any_irq, en_irq, irq_gate;
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction
   function automatic logic known_addr(input logic [PDMC_ADDR_W-1:0] a);
      return (a == PDMC_OFS_CSW) || (a == PDMC_OFS_IEW) ||
             (a == PDMC_OFS_STAT) || (a == PDMC_OFS_CFG);
   endfunction
   pdmc_sync #(.W(IRQ_W)) u_irq_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(irq_i),
      .level_o(irq_s)
   );
   pdmc_sync #(.W(1)) u_wake_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(pll_reset_wake_i),
      .level_o(relock_s)
   );
   pdmc_axil u_axil (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .awaddr_i(s_axil_awaddr_i),
      .awvalid_i(s_axil_awvalid_i),
      .awready_o(s_axil_awready_o),
      .wdata_i(s_axil_wdata_i),
      .wstrb_i(s_axil_wstrb_i),
      .wvalid_i(s_axil_wvalid_i),
      .wready_o(s_axil_wready_o),
      .bresp_o(s_axil_bresp_o),
      .bvalid_o(s_axil_bvalid_o),
      .bready_i(s_axil_bready_i),
      .araddr_i(s_axil_araddr_i),
      .arvalid_i(s_axil_arvalid_i),
      .arready_o(s_axil_arready_o),
      .rdata_o(s_axil_rdata_o),
      .rresp_o(s_axil_rresp_o),
      .rvalid_o(s_axil_rvalid_o),
      .rready_i(s_axil_rready_i),
      .wr_o(wr),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_ok_i(rd_ok),
      .wr_ok_i(wr_ok)
   );
   assign any_irq = |irq_s;
   assign en_irq = |(irq_s & q.iew);
   assign irq_gate = q.csw[PDMC_GLB_EN_BIT] && q.iew[PDMC_NMI_EN_BIT];
   assign rd_ok = known_addr(rd_addr);
   assign wr_ok = known_addr(wr_addr);
   always_comb begin
      case (rd_addr)
         PDMC_OFS_CSW: rd_data = q.csw;
         PDMC_OFS_IEW: rd_data = 32'(q.iew);
         PDMC_OFS_STAT: rd_data = {26'h0, q.resume, q.isr, q.x1, q.st};
         PDMC_OFS_CFG: rd_data = 32'(q.pll_wait);
         default: rd_data = 32'h0000_0000;
      endcase
   end
   always_comb begin
      d = q;
      // strap caught once after reset release, never under reset
      if (!q.strap_done) begin
         d.strap_done = 1'b1;
         d.x1 = clock_multiplier_select_i;
      end
      d.isr = 1'b0;
      d.resume = 1'b0;
      // registers are writable only in the run state, not while a mode change is armed
      if (wr && (q.st == PDMC_RUN)) begin
         if (wr_addr == PDMC_OFS_CSW) begin
            // whole field taken from one write; bit 15 kept as written
            d.csw = strb_merge(q.csw, wr_data, wr_strb) & PDMC_CSW_WMASK;
            d.armed = d.csw[PDMC_PDS_LSB +: PDMC_PDS_W];
            d.dly = PDMC_LIGHT_DLY;
            d.st = PDMC_ARM;
         end else if (wr_addr == PDMC_OFS_IEW) begin
            d.iew = IRQ_W'(strb_merge(32'(q.iew), wr_data, wr_strb));
         end
      end
      case (q.st)
         PDMC_RUN: begin
         end
         PDMC_ARM: begin
            // reserved codes and run code fall back to run
            if (q.dly == 4'h1) begin
               case (q.armed)
                  PDMC_PDS_LIGHT_EN, PDMC_PDS_LIGHT_ANY: d.st = PDMC_LIGHT;
                  PDMC_PDS_HALT: d.st = PDMC_HALT;
                  PDMC_PDS_PLLSTOP: d.st = PDMC_PLLSTOP;
                  default: d.st = PDMC_RUN;
               endcase
            end else begin
               d.dly = q.dly - 4'h1;
            end
         end
         PDMC_LIGHT: begin
            if (en_irq) begin
               d.st = PDMC_RUN;
               d.isr = irq_gate;
               d.resume = !irq_gate;
            end else if (any_irq && q.armed == PDMC_PDS_LIGHT_ANY) begin
               d.st = PDMC_RUN;
               d.resume = 1'b1;
            end
         end
         // deep modes: nothing but reset leaves them
         PDMC_HALT: begin
         end
         PDMC_PLLSTOP: begin
         end
         PDMC_LOCK: begin
            if (q.lock_cnt != 32'h0000_0000) begin
               d.lock_cnt = q.lock_cnt - 32'h0000_0001;
            end else if (pll_locked_i) begin
               d.st = PDMC_RUN;
               d.pll_wait = 1'b0;
            end
         end
         default: d.st = PDMC_RUN;
      endcase
      // a reset that ends the deepest mode asks for relock before running
      if (q.strap_done && relock_s && !q.x1 && q.st == PDMC_RUN
          && !q.pll_wait && q.csw == PDMC_CSW_RST) begin
         d.st = PDMC_LOCK;
         d.pll_wait = 1'b1;
         d.lock_cnt = 32'(LOCK_CYC);
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign cpu_clock_en_o = (q.st == PDMC_RUN) || (q.st == PDMC_ARM);
   assign dma_clock_en_o = (q.st != PDMC_HALT) && (q.st != PDMC_PLLSTOP)
                           && (q.st != PDMC_LOCK);
   assign intr_logic_en_o = dma_clock_en_o;
   assign pll_bypass_o = q.x1;
   assign pll_out_en_o = (q.st != PDMC_HALT) && (q.st != PDMC_PLLSTOP)
                         && !q.x1;
   assign pll_in_en_o = (q.st != PDMC_PLLSTOP);
   assign io_freeze_o = (q.st == PDMC_HALT) || (q.st == PDMC_PLLSTOP);
   assign wake_isr_o = q.isr;
   assign wake_resume_o = q.resume;
   assign mode_o = q.st;

   light_delay_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr && q.st == PDMC_RUN && wr_addr == PDMC_OFS_CSW
      && wr_data[PDMC_PDS_LSB +: PDMC_PDS_W] == PDMC_PDS_LIGHT_EN
      && (&wr_strb) |-> ##9 (q.st == PDMC_LIGHT))
      else $error("light sleep not entered on time");
   deep_stays_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (q.st == PDMC_HALT) |=> (q.st == PDMC_HALT))
      else $error("halt mode left without reset");
   pllstop_stays_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (q.st == PDMC_PLLSTOP) |=> (q.st == PDMC_PLLSTOP && !pll_in_en_o))
      else $error("pll input stop left without reset");
   isr_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wake_isr_o |-> $past(irq_gate) && $past(q.st) == PDMC_LIGHT)
      else $error("service routine without enables");
   cpu_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (q.st == PDMC_LIGHT) |-> !cpu_clock_en_o && dma_clock_en_o)
      else $error("light sleep clock gating wrong");
   freeze_out_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (q.st == PDMC_HALT) |-> io_freeze_o && !pll_out_en_o)
      else $error("halt mode does not freeze");
   any_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.st == PDMC_LIGHT && q.armed == PDMC_PDS_LIGHT_ANY && any_irq
      |=> q.st == PDMC_RUN && (wake_isr_o || wake_resume_o))
      else $error("any interrupt did not wake");
   en_only_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.st == PDMC_LIGHT && q.armed == PDMC_PDS_LIGHT_EN && !en_irq
      |=> q.st == PDMC_LIGHT)
      else $error("woke on non-enabled interrupt");
   lock_wait_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(q.pll_wait) |-> ##1 (q.st == PDMC_LOCK)[*4])
      else $error("relock wait cut short");
   cv_light_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      q.st == PDMC_LIGHT ##1 wake_isr_o);
   cv_resume_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      wake_resume_o);
   cv_halt_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      q.st == PDMC_HALT);
   cv_lock_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      q.st == PDMC_LOCK ##1 q.st == PDMC_RUN);
endmodule

/* testbench/tb_pdmc_top.sv */
`timescale 1ns/1ps
module tb_pdmc_top;
   import pdmc_pkg::*;
   // short relock count keeps the run brief
   localparam int unsigned LOCK_T = 20;
   localparam logic [5:0] CD [5] = '{PDMC_PDS_LIGHT_EN, PDMC_PDS_LIGHT_EN,
      PDMC_PDS_LIGHT_ANY, PDMC_PDS_LIGHT_ANY, PDMC_PDS_LIGHT_EN};
   localparam logic [4:0] GEN = 5'h1D;
   localparam logic [4:0] STRAY = 5'h01;
   localparam logic [4:0] ISR = 5'h09;
   localparam int LN [5] = '{2, 2, 8, 1, 2};
   logic clock_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic [3:0] aw = 4'h0, ar = 4'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
   logic wk = 1'h0, cms = 1'h0, lk = 1'h1;
   logic [15:0] irq = 16'h0000;
   logic awr, wrdy, bv, arr, rv, cpu, dma, intr, byp, pout, pin, frz;
   logic isr, res;
   logic [1:0] bresp, rresp;
   logic [2:0] mode;
   logic [33:0] resp_q[$], wake_q[$];
   int n_mismatch = 0, cmp_count = 0, edge_n = 0, hs_edge = 0;
   logic [31:0] rng = 32'h0001_13DE;

   pdmc_top #(.LOCK_CYC(LOCK_T), .IRQ_W(16)) u_pdmc_top (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .s_axil_awaddr_i(aw), .s_axil_awvalid_i(awv), .s_axil_awready_o(awr),
      .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'hF), .s_axil_wvalid_i(wv),
      .s_axil_wready_o(wrdy), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bv),
      .s_axil_bready_i(br), .s_axil_araddr_i(ar), .s_axil_arvalid_i(arv),
      .s_axil_arready_o(arr), .s_axil_rdata_o(rdat), .s_axil_rresp_o(rresp),
      .s_axil_rvalid_o(rv), .s_axil_rready_i(rr), .irq_i(irq),
      .pll_reset_wake_i(wk), .clock_multiplier_select_i(cms),
      .pll_locked_i(lk), .cpu_clock_en_o(cpu), .dma_clock_en_o(dma),
      .intr_logic_en_o(intr), .pll_bypass_o(byp), .pll_out_en_o(pout),
      .pll_in_en_o(pin), .io_freeze_o(frz), .wake_isr_o(isr),
      .wake_resume_o(res), .mode_o(mode));

   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) edge_n <= edge_n + 1;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // handshakes are judged at the falling edge: inputs only move at the
   // rising edge, so this equals the value the slave sees at the next one
   always @(negedge clock_i) begin
      if (bv === 1'h1 && br)
         chk({bresp, 32'h0}, resp_q.size() ? resp_q.pop_front() : 'x);
      if (rv === 1'h1 && rr)
         chk({rresp, rdat}, resp_q.size() ? resp_q.pop_front() : 'x);
      if (isr === 1'h1 || res === 1'h1)
         chk({32'h0, isr, res}, wake_q.size() ? wake_q.pop_front() : 'x);
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      logic ah, wh, bh, ad, wn;
      ad = 1'h0;
      wn = 1'h0;
      bh = 1'h0;
      resp_q.push_back({e, 32'h0});
      @(posedge clock_i);
      aw <= a;
      awv <= 1'h1;
      wd <= d;
      wv <= 1'h1;
      br <= 1'h1;
      for (int t = 0; t < 60 && !bh; t++) begin
         @(negedge clock_i);
         ah = awv && awr === 1'h1;
         wh = wv && wrdy === 1'h1;
         bh = br && bv === 1'h1;
         if ((ah || wh) && (ah || ad) && (wh || wn)) hs_edge = edge_n + 1;
         ad |= ah;
         wn |= wh;
         @(posedge clock_i);
         if (ah) awv <= 1'h0;
         if (wh) wv <= 1'h0;
         if (bh) br <= 1'h0;
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      logic ah, rh;
      rh = 1'h0;
      resp_q.push_back({e, d});
      @(posedge clock_i);
      ar <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      for (int t = 0; t < 60 && !rh; t++) begin
         @(negedge clock_i);
         ah = arv && arr === 1'h1;
         rh = rr && rv === 1'h1;
         @(posedge clock_i);
         if (ah) arv <= 1'h0;
         if (rh) rr <= 1'h0;
      end
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim);
      int t = 0;
      do @(negedge clock_i); while (mode !== m && ++t < lim);
   endtask

   task automatic do_rst(input logic s, input logic w);
      @(posedge clock_i);
      rst_n_i <= 1'h0;
      cms <= s;
      wk <= w;
      irq <= 16'h0000;
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'h1;
      repeat (2) @(posedge clock_i);
   endtask

   initial begin
      repeat (5000) @(posedge clock_i);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      logic [5:0] c;
      logic low;
      int t0;
      do_rst(1'h0, 1'h0);
      @(negedge clock_i);
      chk(34'({mode, cpu, dma, intr, byp, pout, pin, frz}), 34'({PDMC_RUN, 7'h76}));
      rd(PDMC_OFS_CSW, 32'h0, PDMC_RESP_OK);
      rd(4'h2, 32'h0, PDMC_RESP_SLVERR);
      for (int i = 0; i < 5; i++) begin
         wr(PDMC_OFS_IEW, (i == 4) ? 32'h4 : 32'h6, PDMC_RESP_OK);
         wr(PDMC_OFS_CSW, {16'h0, CD[i], 9'h0, GEN[i]}, PDMC_RESP_OK);
         wait_mode(PDMC_LIGHT, 20);
         chk(34'((edge_n - hs_edge) inside {[8:9]}), 34'h1);
         chk(34'({mode, cpu, dma, intr}), 34'({PDMC_LIGHT, 3'h3}));
         if (STRAY[i]) begin
            @(posedge clock_i);
            irq <= 16'h0100;
            repeat (10) @(posedge clock_i);
            @(negedge clock_i);
            chk(34'(mode), 34'(PDMC_LIGHT));
         end
         wake_q.push_back(34'(ISR[i] ? 2'h2 : 2'h1));
         @(posedge clock_i);
         irq <= irq | (16'h0001 << LN[i]);
         wait_mode(PDMC_RUN, 12);
         chk(34'({mode, cpu}), 34'({PDMC_RUN, 1'h1}));
         @(posedge clock_i);
         irq <= 16'h0000;
         wr(PDMC_OFS_CSW, 32'h0, PDMC_RESP_OK);
         repeat (12) @(posedge clock_i);
      end
      // reserved codes must never stop the cpu clock
      repeat (3) begin
         rng = xs(rng);
         c = {1'h0, rng[4:0]};
         if (c inside {6'h00, 6'h09, 6'h11, 6'h1A, 6'h1C}) c = 6'h05;
         wr(PDMC_OFS_CSW, {16'h0, c, 10'h0}, PDMC_RESP_OK);
         low = 1'h0;
         repeat (14) begin
            @(negedge clock_i);
            low |= (cpu === 1'h0);
         end
         chk(34'({mode, low}), 34'({PDMC_RUN, 1'h0}));
      end
      wr(PDMC_OFS_CSW, 32'h0000_6800, PDMC_RESP_OK);
      wait_mode(PDMC_HALT, 14);
      chk(34'({mode, frz, pout, cpu, dma, pin}), 34'({PDMC_HALT, 5'h11}));
      @(posedge clock_i);
      irq <= 16'hFFFF;
      repeat (20) @(posedge clock_i);
      @(negedge clock_i);
      chk(34'(mode), 34'(PDMC_HALT));
      do_rst(1'h0, 1'h0);
      @(negedge clock_i);
      chk(34'({mode, frz, pout}), 34'({PDMC_RUN, 2'h1}));
      rd(PDMC_OFS_CSW, 32'h0, PDMC_RESP_OK);
      wr(PDMC_OFS_CSW, 32'h0000_7000, PDMC_RESP_OK);
      wait_mode(PDMC_PLLSTOP, 14);
      chk(34'({mode, pin, frz, pout}), 34'({PDMC_PLLSTOP, 3'h2}));
      do_rst(1'h0, 1'h1);
      wait_mode(PDMC_LOCK, 12);
      chk(34'({mode, cpu}), 34'({PDMC_LOCK, 1'h0}));
      t0 = edge_n;
      @(posedge clock_i);
      wk <= 1'h0;
      wait_mode(PDMC_RUN, 60);
      chk(34'((edge_n - t0) inside {[LOCK_T:LOCK_T + 4]}), 34'h1);
      do_rst(1'h1, 1'h0);
      @(negedge clock_i);
      chk(34'({byp, pout}), 34'(2'h2));
      chk(34'(resp_q.size() + wake_q.size()), 34'h0);
      wrap_up();
   end
endmodule
